/* rtc_timeout.sv */
// Top of the receive-timeout counter: register port, mode control,
// receiver strobe synchroniser, interrupt status and mask.
// Assumes a toggle from the receiver's clock domain marks each queue load.
`timescale 1ns/1ps
`default_nettype none
module rtc_timeout (
	input wire logic clk,
	input wire logic nrst,
	input wire logic [3:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [7:0] rdata,
	input wire logic rx_load_toggle,
	output logic irq_out_n,
	output logic timeout_active
);
	import rtc_pkg::*;

	rtc_cnt_if cnt_bus (); // Link to the counter core

	logic [7:0] divisor_high_reg_r; // Upper divisor byte
	logic [7:0] divisor_low_reg_r; // Lower divisor byte
	logic [7:0] irq_mask_reg_r; // Interrupt mask
	logic [7:0] irq_status_reg_r; // Sticky event bits
	logic timer_mode_r; // Ordinary mode: 1 timer, 0 counter
	logic to_mode_r; // Receive-timeout mode active
	rtc_to_state_t to_state_r; // Timeout sequencer
	logic load_r; // Load pulse to the core
	logic run_r; // Run level to the core
	logic [7:0] rdata_r; // Read data, valid one cycle after rd
	logic irq_out_n_r; // Interrupt output flop
	logic sync1_r; // First synchroniser stage
	logic sync2_r; // Second synchroniser stage
	logic sync3_r; // Edge reference
	logic rx_char; // One-cycle pulse per received character
	logic cmd_wr; // Command register write
	logic to_on; // Timeout enable command
	logic to_off; // Timeout disable command
	logic start_cmd; // Ordinary start command
	logic stop_cmd; // Ordinary stop command
	logic [7:0] status_w1c; // Bits software clears this cycle
	logic [7:0] status_set; // Bits hardware sets this cycle
	logic ready_hw_clr; // Hardware clears of the ready flag

	// Register address decode, shared by write and read paths
	function automatic logic hit(input logic [3:0] a, input logic [3:0] ref_a);
		hit = (a == ref_a);
	endfunction

	rtc_counter u_counter (
		.clk(clk),
		.nrst(nrst),
		.cnt(cnt_bus.core)
	);

	assign cnt_bus.load = load_r;
	assign cnt_bus.run = run_r;
	assign cnt_bus.timer = to_mode_r ? 1'b0 : timer_mode_r;
	assign cnt_bus.divisor = {divisor_high_reg_r, divisor_low_reg_r};

	assign rdata = rdata_r;
	assign irq_out_n = irq_out_n_r;
	assign timeout_active = to_mode_r;

	// Command decode; only the upper nibble matters, lower is don't-care
	assign cmd_wr = wr && hit(addr, RTC_ADDR_CMD);
	assign to_on = cmd_wr && wdata[7:4] == RTC_CMD_TO_ON;
	assign to_off = cmd_wr && wdata[7:4] == RTC_CMD_TO_OFF;
	// Start and stop are read-address commands, dead in timeout mode
	assign start_cmd = rd && hit(addr, RTC_ADDR_START) && !to_mode_r;
	assign stop_cmd = rd && hit(addr, RTC_ADDR_STOP) && !to_mode_r;

	// Receiver strobe crossing: two flops, then edge detect on the second
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			sync1_r <= 1'b0;
			sync2_r <= 1'b0;
			sync3_r <= 1'b0;
		end else begin
			sync1_r <= rx_load_toggle;
			sync2_r <= sync1_r;
			sync3_r <= sync2_r;
		end
	end
	assign rx_char = sync2_r ^ sync3_r;

	// Divisor registers; written in any mode, used at next load
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			divisor_high_reg_r <= RTC_RST_DIV_HI;
			divisor_low_reg_r <= RTC_RST_DIV_LO;
		end else if (wr) begin
			if (hit(addr, RTC_ADDR_DIV_HI)) begin
				divisor_high_reg_r <= wdata;
			end
			if (hit(addr, RTC_ADDR_DIV_LO)) begin
				divisor_low_reg_r <= wdata;
			end
		end
	end

	// Mode register: only the timer/counter choice is writable
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			timer_mode_r <= 1'b0;
		end else if (wr && hit(addr, RTC_ADDR_MODE)) begin
			timer_mode_r <= wdata[RTC_BIT_TIMER];
		end
	end

	// Interrupt mask; unused bits are held at zero
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			irq_mask_reg_r <= RTC_RST_MASK;
		end else if (wr && hit(addr, RTC_ADDR_MASK)) begin
			irq_mask_reg_r <= wdata & RTC_EVENT_MASK;
		end
	end

	// Timeout mode flag
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			to_mode_r <= 1'b0;
		end else if (to_on) begin
			to_mode_r <= 1'b1;
		end else if (to_off) begin
			to_mode_r <= 1'b0;
		end
	end

	// Timeout sequencer: a character stops the count for one clock,
	// reloads the divisor, and resumes on the clock after
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			to_state_r <= RTC_TO_OFF;
		end else if (to_on) begin
			to_state_r <= RTC_TO_IDLE;
		end else if (to_off) begin
			to_state_r <= RTC_TO_OFF;
		end else begin
			unique case (to_state_r)
				RTC_TO_OFF: begin
					to_state_r <= RTC_TO_OFF;
				end
				RTC_TO_IDLE: begin
					// Held stopped until the first character arrives
					if (rx_char) begin
						to_state_r <= RTC_TO_LOAD;
					end
				end
				RTC_TO_LOAD: begin
					to_state_r <= RTC_TO_RUN;
				end
				RTC_TO_RUN: begin
					// A new character, even after expiry, restarts the count
					if (rx_char) begin
						to_state_r <= RTC_TO_LOAD;
					end
				end
			endcase
		end
	end

	// Load pulse: ordinary start always reloads; timeout reloads in LOAD
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			load_r <= 1'b0;
		end else begin
			load_r <= start_cmd || (to_mode_r && !to_off && to_state_r == RTC_TO_LOAD);
		end
	end

	// Run level for the core
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			run_r <= 1'b0;
		end else if (to_on || to_off) begin
			// Enable holds the count still; disable leaves it for start
			run_r <= 1'b0;
		end else if (to_mode_r) begin
			if (rx_char) begin
				run_r <= 1'b0;
			end else if (to_state_r == RTC_TO_LOAD) begin
				run_r <= 1'b1;
			end
		end else if (start_cmd) begin
			run_r <= 1'b1;
		end else if (stop_cmd) begin
			run_r <= 1'b0;
		end
	end

	// Sticky status: hardware set wins over any clear in the same cycle
	assign status_set = {4'h0, cnt_bus.expire, 2'b00, rx_char} & RTC_EVENT_MASK;
	assign status_w1c = (wr && hit(addr, RTC_ADDR_STATUS)) ? wdata : 8'h00;
	// Ready also drops on stop, on timeout enable, and on a character
	// in timeout mode, since that character restarts the count
	assign ready_hw_clr = stop_cmd || to_on || (to_mode_r && rx_char);

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			irq_status_reg_r <= 8'h00;
		end else begin
			irq_status_reg_r <= ((irq_status_reg_r & ~status_w1c) & ~({4'h0, ready_hw_clr, 3'b000}))
				| status_set;
		end
	end

	// Active-low interrupt, high while nothing unmasked is pending;
	// a late character can withdraw it before the host reads status
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			irq_out_n_r <= 1'b1;
		end else begin
			irq_out_n_r <= ~|(irq_status_reg_r & irq_mask_reg_r);
		end
	end

	// Read data: counter and timeout modes show the live count, timer mode the divisor
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rdata_r <= 8'h00;
		end else if (rd) begin
			unique case (addr)
				RTC_ADDR_MODE: begin
					rdata_r <= {run_r, to_mode_r, 5'b00000, timer_mode_r};
				end
				RTC_ADDR_MASK: begin
					rdata_r <= irq_mask_reg_r;
				end
				RTC_ADDR_STATUS: begin
					rdata_r <= irq_status_reg_r;
				end
				RTC_ADDR_DIV_HI: begin
					rdata_r <= cnt_bus.timer ? divisor_high_reg_r : cnt_bus.count[15:8];
				end
				RTC_ADDR_DIV_LO: begin
					rdata_r <= cnt_bus.timer ? divisor_low_reg_r : cnt_bus.count[7:0];
				end
				default: begin
					// Commands, write-only and unmapped offsets read zero
					rdata_r <= 8'h00;
				end
			endcase
		end else begin
			rdata_r <= 8'h00;
		end
	end
endmodule
`default_nettype wire

/* rtc_pkg.sv */
// Constants, encodings and register map for the receive-timeout counter block.
// Assumes a single 50 MHz clock domain and a simple strobe register port.
// Overview of operation
// - Timeout mode ignores ordinary start/stop commands
// - Char load: stop, reload divisor, restart
// - Expiry before next char sets ready flag
// - Mask bit 3 gates ready onto interrupt
// - Char after expiry restarts, clears ready
// - Command upper nibble A enables timeout
// - Enable clears ready, holds counter stopped
// - Command upper nibble C disables timeout
// - Two counter operations, mode dependent behaviour
// - Sixteen-bit down counter loaded from divisors
// - One active-low interrupt from unmasked events
package rtc_pkg;
	// Register offsets on the 4-bit address port
	localparam logic [3:0] RTC_ADDR_MODE = 4'h0;
	localparam logic [3:0] RTC_ADDR_CMD = 4'h2;
	localparam logic [3:0] RTC_ADDR_MASK = 4'h4;
	localparam logic [3:0] RTC_ADDR_STATUS = 4'h5;
	localparam logic [3:0] RTC_ADDR_DIV_HI = 4'h6;
	localparam logic [3:0] RTC_ADDR_DIV_LO = 4'h7;
	localparam logic [3:0] RTC_ADDR_START = 4'hE;
	localparam logic [3:0] RTC_ADDR_STOP = 4'hF;
	// Field positions
	localparam int RTC_BIT_RXCHAR = 0;
	localparam int RTC_BIT_READY = 3;
	localparam int RTC_BIT_TIMER = 0;
	localparam int RTC_BIT_TOMODE = 6;
	localparam int RTC_BIT_RUN = 7;
	// Valid status and mask bits
	localparam logic [7:0] RTC_EVENT_MASK = 8'h09;
	// Command opcodes in the upper nibble
	localparam logic [3:0] RTC_CMD_TO_ON = 4'hA;
	localparam logic [3:0] RTC_CMD_TO_OFF = 4'hC;
	// Reset values
	localparam logic [7:0] RTC_RST_DIV_HI = 8'h00;
	localparam logic [7:0] RTC_RST_DIV_LO = 8'h00;
	localparam logic [7:0] RTC_RST_MASK = 8'h00;
	localparam logic [15:0] RTC_RST_COUNT = 16'hFFFF;
	// Timeout sequencing states
	typedef enum logic [3:0] {
		RTC_TO_IDLE = 4'b0001,
		RTC_TO_LOAD = 4'b0010,
		RTC_TO_RUN = 4'b0100,
		RTC_TO_OFF = 4'b1000
	} rtc_to_state_t;
endpackage

/* rtc_cnt_if.sv */
// Interface joining the control logic to the 16-bit counter core.
// Assumes both ends share one clock; all fields come from flip-flops.
`timescale 1ns/1ps
`default_nettype none
interface rtc_cnt_if;
	logic load; // Pulse: copy divisor into counter
	logic run; // Level: counter decrements while high
	logic timer; // Level: square-wave timer behaviour
	logic [15:0] divisor; // Reload value
	logic [15:0] count; // Present count
	logic expire; // Pulse: counter finished a count
	modport ctl (output load, output run, output timer, output divisor, input count, input expire);
	modport core (input load, input run, input timer, input divisor, output count, output expire);
endinterface
`default_nettype wire

/* rtc_counter.sv */
// Sixteen-bit down counter with counter and timer behaviours.
// Assumes load and run come from flops of the same clock domain.
`timescale 1ns/1ps
`default_nettype none
module rtc_counter (
	input wire logic clk,
	input wire logic nrst,
	rtc_cnt_if.core cnt
);
	import rtc_pkg::*;

	logic [15:0] count_r; // Working count
	logic wave_r; // Timer output level
	logic expire_r; // Registered expiry pulse

	assign cnt.count = count_r;
	assign cnt.expire = expire_r;

	// Count down; load wins over counting so a restart is always clean
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			count_r <= RTC_RST_COUNT;
		end else if (cnt.load) begin
			count_r <= cnt.divisor;
		end else if (cnt.run) begin
			if (count_r == 16'h0000 && cnt.timer) begin
				count_r <= cnt.divisor;
			end else begin
				count_r <= count_r - 16'h0001;
			end
		end
	end

	// Timer output toggles each half period; counter mode drops it once
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			wave_r <= 1'b1;
		end else if (cnt.load) begin
			wave_r <= 1'b1;
		end else if (cnt.run && count_r == 16'h0000) begin
			wave_r <= cnt.timer ? ~wave_r : 1'b0;
		end
	end

	// Ready event on the output's fall only, so rollover stays silent
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			expire_r <= 1'b0;
		end else begin
			expire_r <= cnt.run && !cnt.load && count_r == 16'h0000 && wave_r;
		end
	end
endmodule
`default_nettype wire

/* rtc_timeout_assertions.sv */
// Port-level checks for the receive-timeout counter top.
// Assumes one clock domain and the constants of rtc_pkg.
`timescale 1ns/1ps
`default_nettype none
module rtc_timeout_chk
	import rtc_pkg::*;
(
	input wire logic clk,
	input wire logic nrst,
	input wire logic [3:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	input wire logic [7:0] rdata,
	input wire logic rx_load_toggle,
	input wire logic irq_out_n,
	input wire logic timeout_active
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);
	// A command write carrying one opcode
	sequence cmd_s(logic [3:0] op);
		wr && addr == RTC_ADDR_CMD && wdata[7:4] == op;
	endsequence
	// A read of one address
	sequence rd_s(logic [3:0] a);
		rd && addr == a;
	endsequence
	mode_on_a: assert property (cmd_s(RTC_CMD_TO_ON) |=> timeout_active)
		else $error("timeout mode not entered");
	mode_off_a: assert property (cmd_s(RTC_CMD_TO_OFF) |=> !timeout_active)
		else $error("timeout mode not left");
	mode_hold_a: assert property ($changed(timeout_active) |-> $past(wr && addr == RTC_ADDR_CMD))
		else $error("mode changed without a command");
	mode_read_a: assert property (rd_s(RTC_ADDR_MODE) |=> rdata[RTC_BIT_TOMODE] == $past(timeout_active))
		else $error("mode bit reads wrong");
	start_stop_a: assert property (rd_s(RTC_ADDR_START) or rd_s(RTC_ADDR_STOP) |=> rdata == 8'h00)
		else $error("start or stop read not zero");
	rdata_idle_a: assert property (!rd |=> rdata == 8'h00)
		else $error("read data outside read slot");
	status_bits_a: assert property (rd_s(RTC_ADDR_STATUS) |=> (rdata & ~RTC_EVENT_MASK) == 8'h00)
		else $error("status shows unused bits");
	mask_bits_a: assert property (rd_s(RTC_ADDR_MASK) |=> (rdata & ~RTC_EVENT_MASK) == 8'h00)
		else $error("mask shows unused bits");
	mask_off_a: assert property (wr && addr == RTC_ADDR_MASK && wdata == 8'h00 |-> ##[1:2] irq_out_n)
		else $error("interrupt stays with mask clear");
endmodule
bind rtc_timeout rtc_timeout_chk rtc_timeout_chk_i (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata),
	.wr(wr), .rd(rd), .rdata(rdata), .rx_load_toggle(rx_load_toggle), .irq_out_n(irq_out_n),
	.timeout_active(timeout_active));
`default_nettype wire

/* rtc_rx_model.sv */
// Receiver stand-in: flips its toggle once per character queued.
// Assumes send is a one-cycle request from the bench.
`timescale 1ns/1ps
`default_nettype none
module rtc_rx_model (
	input wire logic clk,
	input wire logic nrst,
	input wire logic send,
	output logic rx_load_toggle
);
	// Flop output keeps the toggle glitch-free for the synchroniser
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rx_load_toggle <= 1'b0;
		end else if (send) begin
			rx_load_toggle <= ~rx_load_toggle;
		end
	end
endmodule
`default_nettype wire

/* tb.sv */
// Self-checking bench for the receive-timeout counter.
// Assumes the receiver model drives the toggle input.
`timescale 1ns/1ps
`default_nettype none
module tb;
	import rtc_pkg::*;
	logic clk, nrst, wr, rd, send, rx_load_toggle, irq_out_n, timeout_active;
	logic [3:0] addr;
	logic [7:0] wdata, rdata, v, w;
	int error_cnt, total_checks, n;
	rtc_timeout rtc_timeout_i (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata), .rx_load_toggle(rx_load_toggle), .irq_out_n(irq_out_n), .timeout_active(timeout_active));
	rtc_rx_model rtc_rx_model_i (.clk(clk), .nrst(nrst), .send(send), .rx_load_toggle(rx_load_toggle));
	// Free-running 50 MHz clock
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	// Compare and count
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wreg(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	// Data is taken just after the edge that follows the strobe
	task automatic rreg(input logic [3:0] a, output logic [7:0] d);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		d = rdata;
	endtask
	task automatic rchk(input logic [3:0] a, input logic [7:0] e);
		rreg(a, v);
		chk(v, e);
	endtask
	// Two reads with no gap, to see the count move by one
	task automatic rd2(input logic [3:0] a);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		#1;
		v = rdata;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		w = rdata;
	endtask
	task automatic ticks(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask
	task automatic char();
		@(posedge clk);
		send <= 1'b1;
		@(posedge clk);
		send <= 1'b0;
	endtask
	// Bounded wait on the interrupt line; n holds cycles spent
	task automatic wait_irq(input logic lvl, input int lim);
		n = 0;
		while (irq_out_n !== lvl && n < lim) begin
			ticks(1);
			n++;
		end
		if (irq_out_n !== lvl) begin
			error_cnt++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, irq_out_n, lvl);
			stop_test();
		end
	endtask
	task automatic stop_test();
		$display("checks %0d mismatches %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	initial begin
		{nrst, wr, rd, send, addr, wdata} = '0;
		error_cnt = 0;
		total_checks = 0;
		repeat (3) @(posedge clk);
		nrst <= 1'b1;
		rchk(RTC_ADDR_MODE, 8'h00);
		rchk(RTC_ADDR_DIV_LO, 8'hFF);
		rchk(RTC_ADDR_STATUS, 8'h00);
		chk({7'h00, irq_out_n}, 8'h01);
		wreg(RTC_ADDR_MASK, 8'hFF);
		rchk(RTC_ADDR_MASK, 8'h09);
		wreg(RTC_ADDR_DIV_HI, 8'h00);
		wreg(RTC_ADDR_DIV_LO, 8'h40);
		wreg(4'h9, 8'h55);
		rchk(4'h9, 8'h00);
		rchk(RTC_ADDR_START, 8'h00);
		rchk(RTC_ADDR_MODE, 8'h80);
		wait_irq(1'b0, 120);
		// Only the ready bit may interrupt, or each character would hold the line low
		wreg(RTC_ADDR_MASK, 8'h08);
		wreg(RTC_ADDR_CMD, 8'hA5);
		ticks(2);
		chk({7'h00, timeout_active}, 8'h01);
		chk({7'h00, irq_out_n}, 8'h01);
		rchk(RTC_ADDR_STATUS, 8'h00);
		rchk(RTC_ADDR_START, 8'h00);
		rchk(RTC_ADDR_MODE, 8'h40);
		ticks(100);
		chk({7'h00, irq_out_n}, 8'h01);
		char();
		wait_irq(1'b0, 200);
		chk(8'(n >= 64 && n <= 80), 8'h01);
		rchk(RTC_ADDR_STATUS, 8'h09);
		char();
		ticks(6);
		chk({7'h00, irq_out_n}, 8'h01);
		rchk(RTC_ADDR_STATUS, 8'h01);
		rchk(RTC_ADDR_STOP, 8'h00);
		rchk(RTC_ADDR_MODE, 8'hC0);
		rd2(RTC_ADDR_DIV_LO);
		chk(w, v - 8'h01);
		wreg(RTC_ADDR_STATUS, 8'h01);
		rchk(RTC_ADDR_STATUS, 8'h00);
		wreg(RTC_ADDR_CMD, 8'hC3);
		ticks(1);
		chk({7'h00, timeout_active}, 8'h00);
		rchk(RTC_ADDR_START, 8'h00);
		rchk(RTC_ADDR_MODE, 8'h80);
		rchk(RTC_ADDR_STOP, 8'h00);
		rchk(RTC_ADDR_MODE, 8'h00);
		// Timer behaviour: divisor reads back, ready on the output's fall
		wreg(RTC_ADDR_MODE, 8'h01);
		rchk(RTC_ADDR_START, 8'h00);
		rchk(RTC_ADDR_MODE, 8'h81);
		rchk(RTC_ADDR_DIV_LO, 8'h40);
		wait_irq(1'b0, 120);
		rchk(RTC_ADDR_STOP, 8'h00);
		ticks(2);
		chk({7'h00, irq_out_n}, 8'h01);
		rchk(RTC_ADDR_STATUS, 8'h00);
		wreg(RTC_ADDR_MASK, 8'h00);
		ticks(2);
		chk({7'h00, irq_out_n}, 8'h01);
		stop_test();
	end
endmodule
`default_nettype wire
